/* lpbrk_map.svh */
/*
 * Constants for the standby and break control block: opcodes, vectors,
 * flag positions and timing.
 * Assumes a 50 MHz clock; included by its bare name.
 */
`ifndef LPBRK_MAP_SVH
`define LPBRK_MAP_SVH

`define OP_SOFT_TRAP 8'h83
`define OP_TRAP_RETURN 8'h80
`define OP_WAIT_STANDBY 8'h8f
`define OP_STOP_STANDBY 8'h8e
`define VEC_BREAK_HI 16'hfffc
`define VEC_BREAK_MON_HI 16'hfefc
`define CCR_CARRY_BIT 0
`define CCR_ZERO_BIT 1
`define CCR_MASK_BIT 3
`define CCR_RESET 8'h08
`define CLK_PERIOD_NS 20
`define OSC_STAB_NS 81920
`define OSC_STAB_CYC ((`OSC_STAB_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* lpbrk_pkg.sv */
/*
 * Types for the standby and break control block.
 * Assumes nothing of its surroundings.
 */
package lpbrk_pkg;
   typedef enum logic [2:0] {
      ALU_ADD = 3'h0,
      ALU_SUB = 3'h1,
      ALU_LOGIC = 3'h2,
      ALU_SHIFT = 3'h3,
      ALU_BITTEST = 3'h4,
      ALU_NONE = 3'h7
   } alu_kind_t;

   typedef enum logic [3:0] {
      ST_RUN = 4'b0001,
      ST_WAIT = 4'b0010,
      ST_STOP = 4'b0100,
      ST_STAB = 4'b1000
   } power_state_t;
endpackage

/* cpu_lowpower_break_control.sv */
/*
 * Condition flags, standby control and break entry of a small 8-bit core.
 * Assumes the execute unit reports each finished instruction with
 * instr_done, that break_req and wake inputs come from other clock domains
 * or pins, and that the break source drops its request on its own.
 */
`timescale 1ns/100ps
`include "lpbrk_map.svh"

module cpu_lowpower_break_control #(
   parameter int unsigned STAB_CYCLES = `OSC_STAB_CYC
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic instr_done,
   input wire logic [7:0] instr_opcode,
   input wire lpbrk_pkg::alu_kind_t alu_kind,
   input wire logic [8:0] alu_result,
   input wire logic bit_carry,
   input wire logic break_req,
   input wire logic monitor_mode,
   input wire logic irq_any,
   input wire logic irq_external,
   output logic cpu_clock_en,
   output logic [7:0] ccr,
   output logic [7:0] ir_force,
   output logic ir_force_valid,
   output logic [15:0] pc_load,
   output logic pc_load_valid,
   output logic in_break,
   output logic [3:0] power_state
);

   ////////////////////////////////////////////////////////////////////////
   // input synchronisers
   logic [1:0] brk_s_r;
   logic [1:0] mon_s_r;
   logic [1:0] irq_s_r;
   logic [1:0] ext_s_r;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         brk_s_r <= 2'h0;
         mon_s_r <= 2'h0;
         irq_s_r <= 2'h0;
         ext_s_r <= 2'h0;
      end else begin
         brk_s_r <= {brk_s_r[0], break_req};
         mon_s_r <= {mon_s_r[0], monitor_mode};
         irq_s_r <= {irq_s_r[0], irq_any};
         ext_s_r <= {ext_s_r[0], irq_external};
      end
   end

   wire logic brk_q = brk_s_r[1];
   wire logic mon_q = mon_s_r[1];
   wire logic irq_q = irq_s_r[1];
   wire logic ext_q = ext_s_r[1];

   ////////////////////////////////////////////////////////////////////////
   // power state
   lpbrk_pkg::power_state_t ps_r;
   lpbrk_pkg::power_state_t ps_nxt;
   logic [16:0] stab_cnt_r;
   logic in_break_r;
   logic entering_brk;

   function automatic logic is_op(input logic [7:0] op, input logic [7:0] ref_op);
      is_op = instr_done && (op == ref_op);
   endfunction

   // a break pending at completion is served instead of the standby opcode
   assign entering_brk = instr_done && brk_q && !in_break_r && ps_r == lpbrk_pkg::ST_RUN;

   always_comb begin
      ps_nxt = ps_r;
      unique case (ps_r)
         lpbrk_pkg::ST_RUN: begin
            if (!entering_brk && is_op(instr_opcode, `OP_WAIT_STANDBY))
               ps_nxt = lpbrk_pkg::ST_WAIT;
            else if (!entering_brk && is_op(instr_opcode, `OP_STOP_STANDBY))
               ps_nxt = lpbrk_pkg::ST_STOP;
         end
         lpbrk_pkg::ST_WAIT: begin
            if (irq_q)
               ps_nxt = lpbrk_pkg::ST_RUN;
         end
         lpbrk_pkg::ST_STOP: begin
            if (ext_q)
               ps_nxt = lpbrk_pkg::ST_STAB;
         end
         lpbrk_pkg::ST_STAB: begin
            if (stab_cnt_r == 17'(STAB_CYCLES - 1))
               ps_nxt = lpbrk_pkg::ST_RUN;
         end
         default: ps_nxt = lpbrk_pkg::ST_RUN;
      endcase
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b)
         ps_r <= lpbrk_pkg::ST_RUN;
      else
         ps_r <= ps_nxt;
   end

   // counts every stabilization cycle so the clock resumes only when it is all spent
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b)
         stab_cnt_r <= 17'h0;
      else if (ps_r == lpbrk_pkg::ST_STAB)
         stab_cnt_r <= stab_cnt_r + 17'h1;
      else
         stab_cnt_r <= 17'h0;
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         cpu_clock_en <= 1'b1;
         power_state <= 4'h1;
      end else begin
         cpu_clock_en <= ps_nxt == lpbrk_pkg::ST_RUN;
         power_state <= ps_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // condition codes; reset leaves the mask set, interrupt wake leaves it clear
   logic zero_nxt;
   logic carry_nxt;

   always_comb begin
      zero_nxt = ccr[`CCR_ZERO_BIT];
      carry_nxt = ccr[`CCR_CARRY_BIT];
      if (alu_kind != lpbrk_pkg::ALU_NONE)
         zero_nxt = alu_result[7:0] == 8'h00;
      unique case (alu_kind)
         lpbrk_pkg::ALU_ADD: carry_nxt = alu_result[8];
         lpbrk_pkg::ALU_SUB: carry_nxt = alu_result[8];
         lpbrk_pkg::ALU_SHIFT: carry_nxt = bit_carry;
         lpbrk_pkg::ALU_BITTEST: carry_nxt = bit_carry;
         lpbrk_pkg::ALU_LOGIC: carry_nxt = ccr[`CCR_CARRY_BIT];
         lpbrk_pkg::ALU_NONE: carry_nxt = ccr[`CCR_CARRY_BIT];
         default: carry_nxt = ccr[`CCR_CARRY_BIT];
      endcase
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ccr <= `CCR_RESET;
      end else begin
         if (ps_r == lpbrk_pkg::ST_RUN && instr_done) begin
            ccr[`CCR_ZERO_BIT] <= zero_nxt;
            ccr[`CCR_CARRY_BIT] <= carry_nxt;
         end
         if (ps_r == lpbrk_pkg::ST_RUN && ps_nxt != lpbrk_pkg::ST_RUN)
            ccr[`CCR_MASK_BIT] <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // break entry and exit; only sampled at instruction completion so the
   // current instruction is never cut short, and a match on the last cycle
   // is taken in that same cycle
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         in_break_r <= 1'b0;
         ir_force <= 8'h00;
         ir_force_valid <= 1'b0;
         pc_load <= 16'h0000;
         pc_load_valid <= 1'b0;
      end else begin
         ir_force_valid <= entering_brk;
         pc_load_valid <= entering_brk;
         if (entering_brk) begin
            in_break_r <= 1'b1;
            ir_force <= `OP_SOFT_TRAP;
            pc_load <= mon_q ? `VEC_BREAK_MON_HI : `VEC_BREAK_HI;
         end else if (in_break_r && !brk_q && ps_r == lpbrk_pkg::ST_RUN
                      && is_op(instr_opcode, `OP_TRAP_RETURN)) begin
            in_break_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b)
         in_break <= 1'b0;
      else
         in_break <= in_break_r;
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   chk_zero_flag: assert property (@(posedge clock) disable iff (!rst_b)
      ps_r == lpbrk_pkg::ST_RUN && instr_done && alu_kind != lpbrk_pkg::ALU_NONE
      |=> ccr[`CCR_ZERO_BIT] == ($past(alu_result[7:0]) == 8'h00))
      else $error("zero flag wrong");
   chk_carry_add: assert property (@(posedge clock) disable iff (!rst_b)
      ps_r == lpbrk_pkg::ST_RUN && instr_done && alu_kind == lpbrk_pkg::ALU_ADD
      |=> ccr[`CCR_CARRY_BIT] == $past(alu_result[8]))
      else $error("carry flag wrong");
   chk_carry_shift: assert property (@(posedge clock) disable iff (!rst_b)
      ps_r == lpbrk_pkg::ST_RUN && instr_done && alu_kind == lpbrk_pkg::ALU_SHIFT
      |=> ccr[`CCR_CARRY_BIT] == $past(bit_carry))
      else $error("shift carry wrong");
   chk_wait_entry: assert property (@(posedge clock) disable iff (!rst_b)
      ps_r == lpbrk_pkg::ST_RUN && !entering_brk && is_op(instr_opcode, `OP_WAIT_STANDBY)
      |=> !ccr[`CCR_MASK_BIT] && !cpu_clock_en)
      else $error("wait entry wrong");
   chk_stop_entry: assert property (@(posedge clock) disable iff (!rst_b)
      ps_r == lpbrk_pkg::ST_RUN && !entering_brk && is_op(instr_opcode, `OP_STOP_STANDBY)
      |=> !ccr[`CCR_MASK_BIT] && ps_r == lpbrk_pkg::ST_STOP)
      else $error("stop entry wrong");
   chk_stab_hold: assert property (@(posedge clock) disable iff (!rst_b)
      ps_r == lpbrk_pkg::ST_STAB && stab_cnt_r < 17'(STAB_CYCLES - 1) |=> !cpu_clock_en)
      else $error("clock resumed early");
   chk_trap_load: assert property (@(posedge clock) disable iff (!rst_b)
      entering_brk |=> ir_force_valid && ir_force == `OP_SOFT_TRAP)
      else $error("trap opcode missing");
   chk_vector_pick: assert property (@(posedge clock) disable iff (!rst_b)
      entering_brk |=> pc_load == ($past(mon_q) ? `VEC_BREAK_MON_HI : `VEC_BREAK_HI))
      else $error("break vector wrong");
   chk_no_preempt: assert property (@(posedge clock) disable iff (!rst_b)
      ir_force_valid |-> $past(instr_done))
      else $error("break preempted instruction");
   chk_brk_exit: assert property (@(posedge clock) disable iff (!rst_b)
      in_break_r && brk_q |=> in_break_r)
      else $error("break ended while requested");
   chk_carry_sub: assert property (@(posedge clock) disable iff (!rst_b)
      ps_r == lpbrk_pkg::ST_RUN && instr_done && alu_kind == lpbrk_pkg::ALU_SUB
      |=> ccr[`CCR_CARRY_BIT] == $past(alu_result[8]))
      else $error("borrow flag wrong");
   chk_carry_bittest: assert property (@(posedge clock) disable iff (!rst_b)
      ps_r == lpbrk_pkg::ST_RUN && instr_done && alu_kind == lpbrk_pkg::ALU_BITTEST
      |=> ccr[`CCR_CARRY_BIT] == $past(bit_carry))
      else $error("bit test carry wrong");
   chk_flags_hold: assert property (@(posedge clock) disable iff (!rst_b)
      ps_r == lpbrk_pkg::ST_RUN && instr_done && alu_kind == lpbrk_pkg::ALU_NONE
      |=> $stable(ccr[1:0]))
      else $error("flags moved without alu result");
   // the core is clocked off in standby, so a stray done pulse must not touch the flags
   chk_flags_frozen: assert property (@(posedge clock) disable iff (!rst_b)
      ps_r != lpbrk_pkg::ST_RUN |=> $stable(ccr[1:0]))
      else $error("flags moved in standby");
   chk_wait_stays: assert property (@(posedge clock) disable iff (!rst_b)
      ps_r == lpbrk_pkg::ST_WAIT && !irq_q
      |=> ps_r == lpbrk_pkg::ST_WAIT && !cpu_clock_en)
      else $error("wait left without interrupt");
   chk_irq_wakes: assert property (@(posedge clock) disable iff (!rst_b)
      ps_r == lpbrk_pkg::ST_WAIT && irq_q
      |=> ps_r == lpbrk_pkg::ST_RUN && cpu_clock_en && !ccr[`CCR_MASK_BIT])
      else $error("interrupt wake wrong");
   // only reset may set the mask again once standby has cleared it
   chk_mask_stays_clear: assert property (@(posedge clock) disable iff (!rst_b)
      !ccr[`CCR_MASK_BIT] |=> !ccr[`CCR_MASK_BIT])
      else $error("mask set without reset");
   chk_stop_ignores_irq: assert property (@(posedge clock) disable iff (!rst_b)
      ps_r == lpbrk_pkg::ST_STOP && !ext_q |=> ps_r == lpbrk_pkg::ST_STOP)
      else $error("stop left without external interrupt");
   chk_stop_exit: assert property (@(posedge clock) disable iff (!rst_b)
      ps_r == lpbrk_pkg::ST_STOP && ext_q |=> ps_r == lpbrk_pkg::ST_STAB && !cpu_clock_en)
      else $error("stop exit wrong");
   chk_stab_resume: assert property (@(posedge clock) disable iff (!rst_b)
      ps_r == lpbrk_pkg::ST_STAB && stab_cnt_r == 17'(STAB_CYCLES - 1)
      |=> ps_r == lpbrk_pkg::ST_RUN && cpu_clock_en)
      else $error("clock did not resume");
   chk_pc_valid_pulse: assert property (@(posedge clock) disable iff (!rst_b)
      pc_load_valid |=> !pc_load_valid && !ir_force_valid)
      else $error("break pulse too long");
   // a standby opcode that finishes together with a break is dropped
   chk_brk_over_standby: assert property (@(posedge clock) disable iff (!rst_b)
      entering_brk
      |=> ps_r == lpbrk_pkg::ST_RUN && ccr[`CCR_MASK_BIT] == $past(ccr[`CCR_MASK_BIT]))
      else $error("standby taken over break");
   chk_brk_immediate: assert property (@(posedge clock) disable iff (!rst_b)
      instr_done && brk_q && !in_break_r && ps_r == lpbrk_pkg::ST_RUN
      |=> ir_force_valid && pc_load_valid)
      else $error("break entry delayed");
   chk_brk_ends: assert property (@(posedge clock) disable iff (!rst_b)
      in_break_r && !brk_q && ps_r == lpbrk_pkg::ST_RUN
      && is_op(instr_opcode, `OP_TRAP_RETURN) |=> !in_break_r)
      else $error("trap return did not end break");
   cov_wait_wake: cover property (@(posedge clock) disable iff (!rst_b)
      ps_r == lpbrk_pkg::ST_WAIT ##1 ps_r == lpbrk_pkg::ST_RUN);
   cov_stop_wake: cover property (@(posedge clock) disable iff (!rst_b)
      ps_r == lpbrk_pkg::ST_STAB ##1 ps_r == lpbrk_pkg::ST_RUN);
   cov_break_mon: cover property (@(posedge clock) disable iff (!rst_b)
      entering_brk && mon_q);
   cov_break_end: cover property (@(posedge clock) disable iff (!rst_b)
      in_break_r ##1 !in_break_r);
   cov_break_held: cover property (@(posedge clock) disable iff (!rst_b)
      in_break_r && brk_q && is_op(instr_opcode, `OP_TRAP_RETURN));

endmodule

/* brk_src_model.sv */
/*
 * Far side of the standby and break block: the break module, the monitor
 * mode level and the interrupt sources, all as plain levels.
 * Assumes the bench calls set_lines and that the clock runs.
 */
`timescale 1ns/100ps

module brk_src_model (
   input wire logic clock,
   output logic break_req,
   output logic monitor_mode,
   output logic irq_any,
   output logic irq_external
);
   initial begin
      {break_req, monitor_mode, irq_any, irq_external} = 4'h0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // levels only move just after a rising edge, as the real sources do;
   // the break request is dropped by this side alone, never by the core
   task automatic set_lines(input logic [3:0] v);
      @(posedge clock);
      {break_req, monitor_mode, irq_any, irq_external} <= v;
   endtask
endmodule

/* cpu_lowpower_break_control_tb_top.sv */
/*
 * Self-checking bench for the standby and break block.
 * Assumes brk_src_model as far side and a short stabilization count.
 */
`timescale 1ns/100ps
`include "lpbrk_map.svh"

module cpu_lowpower_break_control_tb_top;
   localparam int unsigned STAB = 8;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic instr_done = 1'b0;
   logic [7:0] instr_opcode = 8'h00;
   lpbrk_pkg::alu_kind_t alu_kind = lpbrk_pkg::ALU_NONE;
   logic [8:0] alu_result = 9'h000;
   logic bit_carry = 1'b0;
   logic break_req, monitor_mode, irq_any, irq_external;
   logic cpu_clock_en, ir_force_valid, pc_load_valid, in_break;
   logic [7:0] ccr, ir_force;
   logic [15:0] pc_load;
   logic [3:0] power_state;
   int num_errors = 0;
   int compares = 0;
   int cycles = 0;
   int u;

   cpu_lowpower_break_control #(.STAB_CYCLES(STAB)) dut (.clock, .rst_b, .instr_done,
      .instr_opcode, .alu_kind, .alu_result, .bit_carry, .break_req, .monitor_mode,
      .irq_any, .irq_external, .cpu_clock_en, .ccr, .ir_force, .ir_force_valid,
      .pc_load, .pc_load_valid, .in_break, .power_state);
   brk_src_model src (.clock, .break_req, .monitor_mode, .irq_any, .irq_external);

   initial begin
      forever #10 clock = ~clock;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string w, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", w, e, g);
      end
   endtask

   task automatic wrap_up;
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // returns 1 ns after the edge that took the instruction
   task automatic op(input lpbrk_pkg::alu_kind_t k, input logic [8:0] r, input logic c,
                     input logic [7:0] code);
      @(posedge clock);
      instr_done <= 1'b1;
      alu_kind <= k;
      alu_result <= r;
      bit_carry <= c;
      instr_opcode <= code;
      @(posedge clock);
      instr_done <= 1'b0;
      #1;
   endtask

   task automatic ticks(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic wait_ps(input logic [3:0] v, input int n, output int used);
      used = 0;
      while (power_state !== v && used < n) begin
         ticks(1);
         used++;
      end
   endtask

   task automatic flag(input lpbrk_pkg::alu_kind_t k, input logic [8:0] r, input logic c,
                       input logic [7:0] e);
      op(k, r, c, 8'h00);
      check("ccr", 16'(e), 16'(ccr));
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_flags;
      flag(lpbrk_pkg::ALU_ADD, 9'h100, 1'b0, 8'h0b);
      flag(lpbrk_pkg::ALU_SUB, 9'h1ff, 1'b0, 8'h09);
      flag(lpbrk_pkg::ALU_LOGIC, 9'h000, 1'b0, 8'h0b);
      flag(lpbrk_pkg::ALU_SHIFT, 9'h080, 1'b0, 8'h08);
      flag(lpbrk_pkg::ALU_BITTEST, 9'h000, 1'b1, 8'h0b);
      flag(lpbrk_pkg::ALU_NONE, 9'h000, 1'b0, 8'h0b);
      flag(lpbrk_pkg::ALU_ADD, 9'h0ff, 1'b0, 8'h08);
      flag(lpbrk_pkg::ALU_LOGIC, 9'h1ff, 1'b0, 8'h08);
      $display("flags test done");
   endtask

   task automatic t_wait;
      op(lpbrk_pkg::ALU_NONE, 9'h000, 1'b0, `OP_WAIT_STANDBY);
      check("state", 16'h0002, 16'(power_state));
      check("clk_en", 16'h0000, 16'(cpu_clock_en));
      check("mask", 16'h0000, 16'(ccr[3]));
      src.set_lines(4'b0010);
      wait_ps(4'h1, 8, u);
      check("clk_en", 16'h0001, 16'(cpu_clock_en));
      check("mask", 16'h0000, 16'(ccr[3]));
      src.set_lines(4'b0000);
      op(lpbrk_pkg::ALU_NONE, 9'h000, 1'b0, `OP_WAIT_STANDBY);
      check("state", 16'h0002, 16'(power_state));
      @(posedge clock);
      rst_b <= 1'b0;
      @(posedge clock);
      rst_b <= 1'b1;
      #1;
      check("ccr", 16'h0008, 16'(ccr));
      check("state", 16'h0001, 16'(power_state));
      check("clk_en", 16'h0001, 16'(cpu_clock_en));
      $display("wait test done");
   endtask

   task automatic t_stop;
      op(lpbrk_pkg::ALU_NONE, 9'h000, 1'b0, `OP_STOP_STANDBY);
      check("mask", 16'h0000, 16'(ccr[3]));
      src.set_lines(4'b0010);
      ticks(6);
      check("state", 16'h0004, 16'(power_state));
      src.set_lines(4'b0001);
      wait_ps(4'h8, 8, u);
      check("clk_en", 16'h0000, 16'(cpu_clock_en));
      wait_ps(4'h1, 3 * STAB, u);
      check("stab", 16'(STAB), 16'(u));
      check("clk_en", 16'h0001, 16'(cpu_clock_en));
      check("mask", 16'h0000, 16'(ccr[3]));
      src.set_lines(4'b0000);
      $display("stop test done");
   endtask

   // the entry op carries a wait opcode, which the break must discard
   task automatic t_break(input logic m);
      src.set_lines({1'b1, m, 2'b00});
      repeat (4) begin
         ticks(1);
         check("trap_v", 16'h0000, 16'(ir_force_valid));
      end
      op(lpbrk_pkg::ALU_NONE, 9'h000, 1'b0, `OP_WAIT_STANDBY);
      check("trap_v", 16'h0001, 16'(ir_force_valid));
      check("trap", 16'h0083, 16'(ir_force));
      check("vec_v", 16'h0001, 16'(pc_load_valid));
      check("vec", m ? 16'hfefc : 16'hfffc, pc_load);
      check("state", 16'h0001, 16'(power_state));
      ticks(1);
      check("in_brk", 16'h0001, 16'(in_break));
      op(lpbrk_pkg::ALU_NONE, 9'h000, 1'b0, `OP_TRAP_RETURN);
      ticks(2);
      check("in_brk", 16'h0001, 16'(in_break));
      check("trap_v", 16'h0000, 16'(ir_force_valid));
      src.set_lines({1'b0, m, 2'b00});
      ticks(3);
      op(lpbrk_pkg::ALU_NONE, 9'h000, 1'b0, `OP_TRAP_RETURN);
      ticks(1);
      check("in_brk", 16'h0000, 16'(in_break));
      $display("break test done");
   endtask

   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         $display("[ERR] run_length expected below 3000 seen 3000");
         wrap_up();
      end
   end

   initial begin
      repeat (3) @(posedge clock);
      rst_b <= 1'b1;
      ticks(1);
      check("ccr", 16'h0008, 16'(ccr));
      check("clk_en", 16'h0001, 16'(cpu_clock_en));
      t_flags();
      t_wait();
      t_stop();
      t_break(1'b0);
      t_break(1'b1);
      wrap_up();
   end
endmodule
